// file: common/eic_defs.vh
// constants for the external pin and pin-change interrupt controller
`ifndef EIC_DEFS_VH
`define EIC_DEFS_VH

// ----------
// register indices (byte address is four times the index)
// ----------
`define EIC_IDX_ENABLE_MASK   6'h3b
`define EIC_IDX_FLAG_STATUS   6'h3a
`define EIC_IDX_CORE_CONTROL  6'h35
`define EIC_IDX_STATUS_WORD   6'h3f

// ----------
// field positions
// ----------
`define EIC_BIT_EXT           6
`define EIC_BIT_PC            5
`define EIC_BIT_GIE           7
`define EIC_SENSE_HI          1
`define EIC_SENSE_LO          0

// ----------
// reset values and encodings
// ----------
`define EIC_RST_ENABLE        8'h00
`define EIC_RST_FLAG          8'h00
`define EIC_RST_SENSE         2'h0
`define EIC_SENSE_LOW         2'h0
`define EIC_SENSE_ANY         2'h1
`define EIC_SENSE_FALL        2'h2
`define EIC_SENSE_RISE        2'h3
`define EIC_VEC_EXT           9'h001
`define EIC_VEC_PC            9'h002
`define EIC_RESP_OKAY         2'h0
`define EIC_RESP_SLVERR       2'h2

// ----------
// timing
// ----------
`define EIC_RETURN_CYCLES     3'h4
`define EIC_PC_WIDTH          9
`define EIC_PORT_PINS         6

`endif

// file: logic/eic_pin_sense.v
// pin sampling, sense control and change detection
`timescale 1ns/1ps
`include "eic_defs.vh"

module eic_pin_sense
(
    input  wire                      aclk,
    input  wire                      aresetn,
    input  wire                      ce,
    input  wire [1:0]                sense,
    input  wire                      ext_pin,
    input  wire [`EIC_PORT_PINS-1:0] port_pins,
    output wire                      ext_event,
    output wire                      ext_level_low,
    output wire                      pc_event
);

    reg                      ext_now;
    reg                      ext_prev;
    reg [`EIC_PORT_PINS-1:0] pin_now;
    reg [`EIC_PORT_PINS-1:0] pin_prev;
    wire [`EIC_PORT_PINS-1:0] pin_chg;

    // ----------------------------------------------------------------
    // sample then compare; pin direction is not looked at on purpose
    // ----------------------------------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ext_now  <= 1'b1;
            ext_prev <= 1'b1;
            pin_now  <= {`EIC_PORT_PINS{1'b0}};
            pin_prev <= {`EIC_PORT_PINS{1'b0}};
        end
        else if (ce)
        begin
            ext_now  <= ext_pin;
            ext_prev <= ext_now;
            pin_now  <= port_pins;
            pin_prev <= pin_now;
        end
    end

    // per pin change detect
    genvar i;
    generate
        for (i = 0; i < `EIC_PORT_PINS; i = i + 1)
        begin : g_chg
            assign pin_chg[i] = pin_now[i] ^ pin_prev[i];
        end
    endgenerate

    assign pc_event = |pin_chg;

    // sense selection; low level gives no edge event
    assign ext_event = (sense == `EIC_SENSE_ANY)  ? (ext_now ^ ext_prev) :
                       (sense == `EIC_SENSE_FALL) ? (ext_prev & ~ext_now) :
                       (sense == `EIC_SENSE_RISE) ? (~ext_prev & ext_now) : 1'b0;
    assign ext_level_low = (sense == `EIC_SENSE_LOW) & ~ext_now;

endmodule

// file: logic/eic_axil_port.v
// axi4-lite slave handshake for the controller registers
`timescale 1ns/1ps
`include "eic_defs.vh"

module eic_axil_port
(
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        ce,
    input  wire [7:0]  s_awaddr,
    input  wire        s_awvalid,
    output reg         s_awready,
    input  wire [31:0] s_wdata,
    input  wire [3:0]  s_wstrb,
    input  wire        s_wvalid,
    output reg         s_wready,
    output reg  [1:0]  s_bresp,
    output reg         s_bvalid,
    input  wire        s_bready,
    input  wire [7:0]  s_araddr,
    input  wire        s_arvalid,
    output reg         s_arready,
    output reg  [31:0] s_rdata,
    output reg  [1:0]  s_rresp,
    output reg         s_rvalid,
    input  wire        s_rready,
    output reg  [5:0]  wr_index,
    output reg  [7:0]  wr_data,
    output wire        wr_pulse,
    input  wire        wr_hit,
    output wire [5:0]  rd_index,
    input  wire [7:0]  rd_data,
    input  wire        rd_hit
);

    reg aw_got;
    reg w_got;
    reg lane0;
    wire both_got;

    assign both_got = aw_got & w_got & ~s_bvalid;
    // only byte lane 0 carries register bits
    assign wr_pulse = both_got & lane0 & wr_hit & ce;
    assign rd_index = s_araddr[7:2];

    // ----------------------------------------------------------------
    // write channel: address and data taken in either order
    // ----------------------------------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_awready <= 1'b1;
            s_wready  <= 1'b1;
            s_bvalid  <= 1'b0;
            s_bresp   <= `EIC_RESP_OKAY;
            aw_got    <= 1'b0;
            w_got     <= 1'b0;
            lane0     <= 1'b0;
            wr_index  <= 6'h00;
            wr_data   <= 8'h00;
        end
        else if (ce)
        begin
            if (s_awvalid && s_awready)
            begin
                aw_got    <= 1'b1;
                wr_index  <= s_awaddr[7:2];
                s_awready <= 1'b0;
            end
            if (s_wvalid && s_wready)
            begin
                w_got    <= 1'b1;
                wr_data  <= s_wdata[7:0];
                lane0    <= s_wstrb[0];
                s_wready <= 1'b0;
            end
            if (both_got)
            begin
                s_bvalid <= 1'b1;
                s_bresp  <= wr_hit ? `EIC_RESP_OKAY : `EIC_RESP_SLVERR;
                aw_got   <= 1'b0;
                w_got    <= 1'b0;
            end
            if (s_bvalid && s_bready)
            begin
                s_bvalid  <= 1'b0;
                s_awready <= 1'b1;
                s_wready  <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // read channel: data captured at the address handshake
    // ----------------------------------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_arready <= 1'b1;
            s_rvalid  <= 1'b0;
            s_rdata   <= 32'h00000000;
            s_rresp   <= `EIC_RESP_OKAY;
        end
        else if (ce)
        begin
            if (s_arvalid && s_arready)
            begin
                s_arready <= 1'b0;
                s_rvalid  <= 1'b1;
                s_rdata   <= {24'h000000, rd_data};
                s_rresp   <= rd_hit ? `EIC_RESP_OKAY : `EIC_RESP_SLVERR;
            end
            else if (s_rvalid && s_rready)
            begin
                s_rvalid  <= 1'b0;
                s_arready <= 1'b1;
            end
        end
    end

endmodule

// file: logic/eic_top.v
// external pin and pin-change interrupt controller with return sequencer
`timescale 1ns/1ps
`include "eic_defs.vh"

// Overview of operation
// - return takes four cycles, restores pc, sets gie
// - one main instruction runs after every return
// - enable register: ext bit 6, change bit 5
// - bit 7 and bits 4..0 read zero
// - ext interrupt needs its enable and gie
// - pin activity counts even when driven out
// - ext interrupt vectors to address 001
// - any pin change vectors to address 002
// - triggering ext edge sets flag bit 6
// - vector only when flag (or low level on ext), enable, gie set
// - ext flag cleared by vector or one-write
// - low-level sensing holds ext flag cleared
// - change sets flag bit 5, cleared likewise
// - sense: low, any, falling, rising edge
// - pins sampled; pulses over one clock caught
module eic_top
(
    input  wire                      aclk,
    input  wire                      aresetn,
    input  wire                      ce,
    input  wire [7:0]                s_awaddr,
    input  wire                      s_awvalid,
    output wire                      s_awready,
    input  wire [31:0]               s_wdata,
    input  wire [3:0]                s_wstrb,
    input  wire                      s_wvalid,
    output wire                      s_wready,
    output wire [1:0]                s_bresp,
    output wire                      s_bvalid,
    input  wire                      s_bready,
    input  wire [7:0]                s_araddr,
    input  wire                      s_arvalid,
    output wire                      s_arready,
    output wire [31:0]               s_rdata,
    output wire [1:0]                s_rresp,
    output wire                      s_rvalid,
    input  wire                      s_rready,
    input  wire                      ext_pin,
    input  wire [`EIC_PORT_PINS-1:0] port_pins,
    input  wire                      instr_boundary,
    input  wire                      irq_return_instr_start,
    input  wire [`EIC_PC_WIDTH-1:0]  stack_pc,
    output reg                       irq,
    output reg                       vector_take,
    output reg  [`EIC_PC_WIDTH-1:0]  vector_addr,
    output reg                       pc_restore_valid,
    output reg  [`EIC_PC_WIDTH-1:0]  pc_restore,
    output reg                       global_ie,
    output reg                       irq_return_instr_busy
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    localparam ST_RUN  = 1'b0;
    localparam ST_IRQ_RETURN_INSTR = 1'b1;
    // whole-register reset words, sliced per bit below
    localparam [7:0] RST_EN = `EIC_RST_ENABLE;
    localparam [7:0] RST_FL = `EIC_RST_FLAG;
    localparam [1:0] RST_SN = `EIC_RST_SENSE;

    reg        state;
    reg [2:0]  ret_cnt;
    reg        skip_one;
    reg        ext_pin_irq_enable;
    reg        pin_change_irq_enable;
    reg        ext_pin_flag;
    reg        pin_change_flag;
    reg        sense_ctrl_hi;
    reg        sense_ctrl_lo;

    wire [5:0] wr_index;
    wire [7:0] wr_data;
    wire       wr_pulse;
    reg        wr_hit;
    wire [5:0] rd_index;
    reg  [7:0] rd_data;
    reg        rd_hit;

    wire       ext_event;
    wire       ext_level_low;
    wire       pc_event;
    wire       level_mode;
    wire       ext_pending;
    wire       pc_pending;
    wire       serve_ok;
    wire       take_ext;
    wire       take_pc;
    wire       wr_enable;
    wire       wr_flag;
    wire       wr_control;
    wire       wr_status;

    // ----------------------------------------------------------------
    // submodules
    // ----------------------------------------------------------------
    eic_axil_port u_port
    (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .ce        (ce),
        .s_awaddr  (s_awaddr),
        .s_awvalid (s_awvalid),
        .s_awready (s_awready),
        .s_wdata   (s_wdata),
        .s_wstrb   (s_wstrb),
        .s_wvalid  (s_wvalid),
        .s_wready  (s_wready),
        .s_bresp   (s_bresp),
        .s_bvalid  (s_bvalid),
        .s_bready  (s_bready),
        .s_araddr  (s_araddr),
        .s_arvalid (s_arvalid),
        .s_arready (s_arready),
        .s_rdata   (s_rdata),
        .s_rresp   (s_rresp),
        .s_rvalid  (s_rvalid),
        .s_rready  (s_rready),
        .wr_index  (wr_index),
        .wr_data   (wr_data),
        .wr_pulse  (wr_pulse),
        .wr_hit    (wr_hit),
        .rd_index  (rd_index),
        .rd_data   (rd_data),
        .rd_hit    (rd_hit)
    );

    eic_pin_sense u_sense
    (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .ce            (ce),
        .sense         ({sense_ctrl_hi, sense_ctrl_lo}),
        .ext_pin       (ext_pin),
        .port_pins     (port_pins),
        .ext_event     (ext_event),
        .ext_level_low (ext_level_low),
        .pc_event      (pc_event)
    );

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    always @*
    begin
        wr_hit = (wr_index == `EIC_IDX_ENABLE_MASK) || (wr_index == `EIC_IDX_FLAG_STATUS) ||
                 (wr_index == `EIC_IDX_CORE_CONTROL) || (wr_index == `EIC_IDX_STATUS_WORD);
        rd_hit = 1'b1;
        rd_data = 8'h00; // reserved bits and unmapped reads give zero
        case (rd_index)
            `EIC_IDX_ENABLE_MASK:
            begin
                rd_data[`EIC_BIT_EXT] = ext_pin_irq_enable;
                rd_data[`EIC_BIT_PC]  = pin_change_irq_enable;
            end
            `EIC_IDX_FLAG_STATUS:
            begin
                rd_data[`EIC_BIT_EXT] = ext_pin_flag;
                rd_data[`EIC_BIT_PC]  = pin_change_flag;
            end
            `EIC_IDX_CORE_CONTROL:
            begin
                rd_data[`EIC_SENSE_HI] = sense_ctrl_hi;
                rd_data[`EIC_SENSE_LO] = sense_ctrl_lo;
            end
            `EIC_IDX_STATUS_WORD:
            begin
                rd_data[`EIC_BIT_GIE] = global_ie;
            end
            default:
            begin
                rd_hit = 1'b0;
            end
        endcase
    end

    assign wr_enable  = wr_pulse && (wr_index == `EIC_IDX_ENABLE_MASK);
    assign wr_flag    = wr_pulse && (wr_index == `EIC_IDX_FLAG_STATUS);
    assign wr_control = wr_pulse && (wr_index == `EIC_IDX_CORE_CONTROL);
    assign wr_status  = wr_pulse && (wr_index == `EIC_IDX_STATUS_WORD);

    // ----------------------------------------------------------------
    // request qualification and priority
    // ----------------------------------------------------------------
    assign level_mode  = ({sense_ctrl_hi, sense_ctrl_lo} == `EIC_SENSE_LOW);
    // low level has no flag: it requests only while the pin stays low
    assign ext_pending = ext_pin_irq_enable & (ext_pin_flag | ext_level_low);
    assign pc_pending  = pin_change_irq_enable & pin_change_flag;
    assign serve_ok    = instr_boundary & global_ie & ~skip_one & (state == ST_RUN) & ~irq_return_instr_start;
    assign take_ext    = serve_ok & ext_pending;
    assign take_pc     = serve_ok & ~ext_pending & pc_pending;

    // ----------------------------------------------------------------
    // enable and sense registers
    // ----------------------------------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ext_pin_irq_enable    <= RST_EN[`EIC_BIT_EXT];
            pin_change_irq_enable <= RST_EN[`EIC_BIT_PC];
            sense_ctrl_hi         <= RST_SN[`EIC_SENSE_HI];
            sense_ctrl_lo         <= RST_SN[`EIC_SENSE_LO];
        end
        else if (ce)
        begin
            if (wr_enable)
            begin
                ext_pin_irq_enable    <= wr_data[`EIC_BIT_EXT];
                pin_change_irq_enable <= wr_data[`EIC_BIT_PC];
            end
            if (wr_control)
            begin
                sense_ctrl_hi <= wr_data[`EIC_SENSE_HI];
                sense_ctrl_lo <= wr_data[`EIC_SENSE_LO];
            end
        end
    end

    // ----------------------------------------------------------------
    // sticky flags: a new event beats a same-cycle clear
    // ----------------------------------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ext_pin_flag    <= RST_FL[`EIC_BIT_EXT];
            pin_change_flag <= RST_FL[`EIC_BIT_PC];
        end
        else if (ce)
        begin
            if (level_mode)
                ext_pin_flag <= 1'b0;
            else if (ext_event)
                ext_pin_flag <= 1'b1;
            else if (take_ext || (wr_flag && wr_data[`EIC_BIT_EXT]))
                ext_pin_flag <= 1'b0;
            if (pc_event)
                pin_change_flag <= 1'b1;
            else if (take_pc || (wr_flag && wr_data[`EIC_BIT_PC]))
                pin_change_flag <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // vector and return sequencer
    // ----------------------------------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state            <= ST_RUN;
            ret_cnt          <= 3'h0;
            skip_one         <= 1'b0;
            global_ie        <= 1'b0;
            vector_take      <= 1'b0;
            vector_addr      <= {`EIC_PC_WIDTH{1'b0}};
            pc_restore_valid <= 1'b0;
            pc_restore       <= {`EIC_PC_WIDTH{1'b0}};
            irq_return_instr_busy        <= 1'b0;
        end
        else if (ce)
        begin
            vector_take      <= 1'b0;
            pc_restore_valid <= 1'b0;
            if (wr_status)
                global_ie <= wr_data[`EIC_BIT_GIE];
            case (state)
                ST_RUN:
                begin
                    if (irq_return_instr_start)
                    begin
                        state     <= ST_IRQ_RETURN_INSTR;
                        ret_cnt   <= 3'h1;
                        irq_return_instr_busy <= 1'b1;
                    end
                    else if (take_ext)
                    begin
                        vector_take <= 1'b1;
                        vector_addr <= `EIC_VEC_EXT;
                        global_ie   <= 1'b0;
                    end
                    else if (take_pc)
                    begin
                        vector_take <= 1'b1;
                        vector_addr <= `EIC_VEC_PC;
                        global_ie   <= 1'b0;
                    end
                    else if (instr_boundary)
                        skip_one <= 1'b0;            // the one instruction has run
                end
                ST_IRQ_RETURN_INSTR:
                begin
                    // four cycles counted from the start pulse
                    if (ret_cnt == `EIC_RETURN_CYCLES - 3'h1)
                    begin
                        state            <= ST_RUN;
                        irq_return_instr_busy        <= 1'b0;
                        pc_restore_valid <= 1'b1;
                        pc_restore       <= stack_pc;
                        global_ie        <= 1'b1;
                        skip_one         <= 1'b1;
                    end
                    ret_cnt <= ret_cnt + 3'h1;
                end
                default:
                begin
                    state <= ST_RUN;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // interrupt line: registered so it is glitch free toward the core
    // ----------------------------------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
            irq <= 1'b0;
        else if (ce)
            irq <= (ext_pending | pc_pending) & global_ie;
    end

endmodule

// file: verif/eic_checker.sv
// concurrent checks on the interrupt controller top ports
`timescale 1ns/1ps
`include "eic_defs.vh"
module eic_checker
(
    input logic        aclk,
    input logic        aresetn,
    input logic        s_awready,
    input logic        s_wready,
    input logic        s_bvalid,
    input logic [7:0]  s_araddr,
    input logic        s_arvalid,
    input logic        s_arready,
    input logic [31:0] s_rdata,
    input logic        s_rvalid,
    input logic        instr_boundary,
    input logic        irq_return_instr_start,
    input logic [8:0]  stack_pc,
    input logic        irq,
    input logic        vector_take,
    input logic        pc_restore_valid,
    input logic [8:0]  pc_restore,
    input logic        global_ie,
    input logic        irq_return_instr_busy
);
    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ----------
    // helper state
    // ----------
    logic       skip_q;
    logic [5:0] rd_idx;
    wire        skip_now = pc_restore_valid | skip_q;
    // skip owed until the first boundary after a return
    always @(posedge aclk)
    begin
        if (!aresetn)
            skip_q <= 1'b0;
        else
            skip_q <= skip_now & ~instr_boundary;
        if (s_arvalid & s_arready)
            rd_idx <= s_araddr[7:2];
    end
    // ----------
    // properties
    // ----------
    sequence s_ret_run;
        irq_return_instr_busy [*3];
    endsequence
    sequence s_ret_end;
        pc_restore_valid && global_ie && !irq_return_instr_busy;
    endsequence
    property p_ret_seq;
        irq_return_instr_start && !irq_return_instr_busy |=> s_ret_run ##1 s_ret_end;
    endproperty
    a_ret_seq: assert property (p_ret_seq) else $error("return timing wrong");
    property p_ret_pc;
        pc_restore_valid |-> pc_restore == $past(stack_pc);
    endproperty
    a_ret_pc: assert property (p_ret_pc) else $error("restored pc wrong");
    property p_skip;
        instr_boundary && skip_now |=> !vector_take;
    endproperty
    a_skip: assert property (p_skip) else $error("vector right after return");
    property p_vec_gate;
        vector_take |-> !global_ie && $past(global_ie && instr_boundary && !irq_return_instr_busy);
    endproperty
    a_vec_gate: assert property (p_vec_gate) else $error("vector not gated");
    property p_irq_gate;
        !global_ie |=> !irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without global enable");
    property p_rsv_zero;
        s_rvalid && (rd_idx == `EIC_IDX_ENABLE_MASK || rd_idx == `EIC_IDX_FLAG_STATUS)
            |-> (s_rdata & 32'hffffff9f) == 32'h0;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits set");
    property p_rd_answer;
        s_arvalid && s_arready |=> s_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
    property p_wr_answer;
        $rose(s_bvalid) |-> $past(!s_awready && !s_wready);
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write answer early");
endmodule

bind eic_top eic_checker eic_checker_i (.*);

// file: verif/eic_core_model.sv
// core model: issues boundaries, runs a short routine, returns
`timescale 1ns/1ps
module eic_core_model
#(
    parameter [8:0] RET_PC = 9'h0a5
)
(
    input  logic       aclk,
    input  logic       aresetn,
    input  logic       run,
    input  logic       vector_take,
    input  logic       irq_return_instr_busy,
    output logic       instr_boundary,
    output logic       irq_return_instr_start,
    output logic [8:0] stack_pc
);
    logic       in_isr;
    logic [1:0] isr_cnt;
    assign stack_pc = RET_PC;
    // routine is four cycles; no boundary is issued in the cycle of the return start
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            instr_boundary <= 1'b0;
            irq_return_instr_start     <= 1'b0;
            in_isr         <= 1'b0;
            isr_cnt        <= 2'h0;
        end
        else
        begin
            irq_return_instr_start     <= 1'b0;
            instr_boundary <= run & ~in_isr & ~irq_return_instr_busy & ~vector_take;
            if (vector_take)
            begin
                in_isr  <= 1'b1;
                isr_cnt <= 2'h3;
            end
            else if (in_isr)
            begin
                isr_cnt <= isr_cnt - 2'h1;
                if (isr_cnt == 2'h0)
                begin
                    irq_return_instr_start <= 1'b1;
                    in_isr     <= 1'b0;
                end
            end
        end
    end
endmodule

// file: verif/test_ext_pinchange_irq_ctrl.sv
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
`include "eic_defs.vh"
module test_ext_pinchange_irq_ctrl;
    logic        aclk, aresetn, ce, run, ext_pin, irq, vector_take, global_ie;
    logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic        s_arvalid, s_arready, s_rvalid, s_rready, irq_return_instr_busy;
    logic        instr_boundary, irq_return_instr_start, pc_restore_valid;
    logic [7:0]  s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata;
    logic [3:0]  s_wstrb;
    logic [1:0]  s_bresp, s_rresp;
    logic [5:0]  port_pins;
    logic [8:0]  stack_pc, vector_addr, pc_restore;
    int          n_mismatch, n_checks;
    localparam logic [7:0] FALL_EXP [4] = '{8'h00, 8'h40, 8'h40, 8'h00};
    localparam logic [7:0] RISE_EXP [4] = '{8'h00, 8'h40, 8'h40, 8'h40};

    eic_top eic_top_i (.*);
    eic_core_model eic_core_model_i (.aclk, .aresetn, .run, .vector_take, .irq_return_instr_busy,
        .instr_boundary, .irq_return_instr_start, .stack_pc);

    always #25 aclk = ~aclk;
    // ----------
    // tasks
    // ----------
    task chk(input logic [8:0] got, input logic [8:0] exp);
    begin
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    // aw and w offered together
    task wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
    begin
        s_awaddr  <= {idx, 2'b00};
        s_wdata   <= {24'h0, d};
        s_awvalid <= 1'b1;
        s_wvalid  <= 1'b1;
        s_bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_awready)
                s_awvalid <= 1'b0;
            if (s_wready)
                s_wvalid <= 1'b0;
        end while (!s_bvalid);
        chk({7'h0, s_bresp}, {7'h0, er});
    end
    endtask
    task rd(input logic [5:0] idx, input logic [7:0] ed, input logic [1:0] er);
    begin
        s_araddr  <= {idx, 2'b00};
        s_arvalid <= 1'b1;
        s_rready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_arready)
                s_arvalid <= 1'b0;
        end while (!s_rvalid);
        chk(s_rdata[8:0], {1'b0, ed});
        chk({7'h0, s_rresp}, {7'h0, er});
    end
    endtask
    // hold pins past the flag latency
    task pins(input logic e, input logic [5:0] p);
    begin
        ext_pin   <= e;
        port_pins <= p;
        repeat (4) @(posedge aclk);
    end
    endtask
    task tally_and_finish;
    begin
        if (n_mismatch == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
    endtask
    // ----------
    // main sequence
    // ----------
    initial
    begin
        aclk = 1'b0;
        ce = 1'b1;
        aresetn = 1'b0;
        run = 1'b0;
        ext_pin = 1'b1;
        port_pins = 6'h00;
        s_wstrb = 4'hf;
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
        {s_awaddr, s_araddr, s_wdata} = 48'h0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`EIC_IDX_ENABLE_MASK, 8'h00, `EIC_RESP_OKAY);
        rd(`EIC_IDX_FLAG_STATUS, 8'h00, `EIC_RESP_OKAY);
        wr(`EIC_IDX_ENABLE_MASK, 8'hff, `EIC_RESP_OKAY);
        rd(`EIC_IDX_ENABLE_MASK, 8'h60, `EIC_RESP_OKAY);
        wr(6'h10, 8'hff, `EIC_RESP_SLVERR);
        rd(6'h10, 8'h00, `EIC_RESP_SLVERR);
        // each sense mode: fall, then rise
        for (int m = 0; m < 4; m++)
        begin
            wr(`EIC_IDX_CORE_CONTROL, m[7:0], `EIC_RESP_OKAY);
            wr(`EIC_IDX_FLAG_STATUS, 8'h60, `EIC_RESP_OKAY);
            pins(1'b0, 6'h00);
            rd(`EIC_IDX_FLAG_STATUS, FALL_EXP[m], `EIC_RESP_OKAY);
            pins(1'b1, 6'h00);
            wr(`EIC_IDX_FLAG_STATUS, 8'h00, `EIC_RESP_OKAY);
            rd(`EIC_IDX_FLAG_STATUS, RISE_EXP[m], `EIC_RESP_OKAY);
        end
        wr(`EIC_IDX_FLAG_STATUS, 8'h40, `EIC_RESP_OKAY);
        rd(`EIC_IDX_FLAG_STATUS, 8'h00, `EIC_RESP_OKAY);
        // port pulse and ext edge, left pending
        port_pins <= 6'h20;
        repeat (2) @(posedge aclk);
        pins(1'b0, 6'h00);
        pins(1'b1, 6'h00);
        rd(`EIC_IDX_FLAG_STATUS, 8'h60, `EIC_RESP_OKAY);
        chk({8'h0, irq}, 9'h000);
        wr(`EIC_IDX_STATUS_WORD, 8'h80, `EIC_RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk({8'h0, irq}, 9'h001);
        wr(`EIC_IDX_ENABLE_MASK, 8'h00, `EIC_RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk({8'h0, irq}, 9'h000);
        wr(`EIC_IDX_ENABLE_MASK, 8'h60, `EIC_RESP_OKAY);
        run <= 1'b1;
        // ext first, change after return
        for (int v = 0; v < 2; v++)
        begin
            do @(posedge aclk); while (!vector_take);
            chk(vector_addr, v[8:0] + 9'h001);
        end
        repeat (12) @(posedge aclk);
        chk({8'h0, global_ie}, 9'h001);
        chk(pc_restore, 9'h0a5);
        rd(`EIC_IDX_FLAG_STATUS, 8'h00, `EIC_RESP_OKAY);
        tally_and_finish;
    end
    // watchdog, far past the run length
    initial
    begin
        repeat (5000) @(posedge aclk);
        n_mismatch++;
        tally_and_finish;
    end
endmodule
